//--- tb/ees_master.sv
// bus master model: drives scl, pulls sda low
// assumes sda_i is the resolved wire with a pull-up
`timescale 1ns/1ps
module ees_master (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // ----
  // bit level
  // ----
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic put_bit(input logic b, output logic r);
    #60 sda_low_o = ~b;
    #100 scl_o = 1'b1;
    #80 r = sda_i;
    #80 scl_o = 1'b0;
  endtask : put_bit
  task automatic start();
    #60 sda_low_o = 1'b0;
    #100 scl_o = 1'b1;
    #80 sda_low_o = 1'b1;
    #80 scl_o = 1'b0;
  endtask : start
  // scl is left high, so the clock stands still between frames
  task automatic stop();
    #60 sda_low_o = 1'b1;
    #100 scl_o = 1'b1;
    #80 sda_low_o = 1'b0;
    #80;
  endtask : stop
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], r);
    put_bit(1'b1, ack);
  endtask : put_byte
  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(mack, r);
  endtask : get_byte
endmodule : ees_master

//--- tb/ees_slave_port_props.sv
// assertions on the pins of the eeprom slave port
// assumes one core clock domain
`timescale 1ns/1ps
module ees_slave_port_props #(
  parameter int WRITE_CYCLES = 64
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic write_protect_i,
  input wire logic standby_o,
  input wire logic prog_busy_o
);
  // ----
  // write cycle length, reset and sda pin checks
  // ----
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  always_comb
  begin
    next_busy_cnt = prog_busy_o ? busy_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= next_busy_cnt;
  end
  AST_PAD_LOW: assert property (sda_oe_o |-> sda_o == 1'b0)
    else $error("sda driven high");
  AST_RESET_IDLE: assert property ($fell(rst_i) |-> standby_o && !prog_busy_o && !sda_oe_o)
    else $error("not idle after reset");
  AST_BUSY_NOT_STANDBY: assert property (prog_busy_o |-> !standby_o)
    else $error("standby during write cycle");
  AST_BUSY_BOUND: assert property (busy_cnt <= 32'(WRITE_CYCLES))
    else $error("write cycle too long");
  AST_BUSY_MIN: assert property ($fell(prog_busy_o) |-> $past(busy_cnt) >= 32'd32)
    else $error("write cycle too short");
  AST_BUSY_QUIET: assert property (prog_busy_o |-> !sda_oe_o)
    else $error("sda driven during write cycle");
  AST_BUSY_START: assert property ($rose(prog_busy_o) |-> scl_i && sda_i && !write_protect_i)
    else $error("write cycle without stop");
  AST_OE_RISE_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("sda pulled while scl high");
  AST_OE_HOLD: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8])
    else $error("sda pull too short");
  AST_STANDBY_QUIET: assert property (standby_o |-> !sda_oe_o)
    else $error("sda driven in standby");
endmodule : ees_slave_port_props
bind ees_slave_port ees_slave_port_props #(.WRITE_CYCLES(WRITE_CYCLES)) props_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .write_protect_i(write_protect_i), .standby_o(standby_o),
  .prog_busy_o(prog_busy_o));

//--- tb/tb_ees_slave_port.sv
// self-checking bench for the eeprom slave port
// assumes the master model owns the link; sda has a pull-up
`timescale 1ns/1ps
module tb_ees_slave_port;
  // ----
  // harness
  // ----
  localparam int WCYC = 400;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl, sda_low, sda_o, sda_oe, standby, busy, ack;
  logic [7:0] d;
  int mismatches = 0;
  int compares = 0;
  wire sda = ~(sda_low | sda_oe);
  always #10 core_clk_i = ~core_clk_i;
  ees_master m_u (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
  ees_slave_port #(.WRITE_CYCLES(WCYC)) dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .chip_select_strap_hi_i(strap[2]),
    .chip_select_strap_mid_i(strap[1]), .chip_select_strap_lo_i(strap[0]),
    .write_protect_i(wp), .standby_o(standby), .prog_busy_o(busy));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  function automatic logic [7:0] dev(input logic rd);
    return {4'ha, strap, rd};
  endfunction : dev
  task automatic snd(input logic [7:0] b);
    m_u.put_byte(b, ack);
    check("ack", {7'h0, ack}, 8'h00);
  endtask : snd
  task automatic set_addr(input logic [12:0] a);
    m_u.start();
    snd(dev(1'b0));
    snd({3'h0, a[12:8]});
    snd(a[7:0]);
  endtask : set_addr
  task automatic rd1(input logic [12:0] a, input logic [7:0] e);
    set_addr(a);
    m_u.start();
    snd(dev(1'b1));
    m_u.get_byte(1'b1, d);
    check("read", d, e);
    m_u.stop();
  endtask : rd1
  // bounded so a stuck write cycle ends the run
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < WCYC)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == WCYC)
    begin
      mismatches++;
      summarize();
    end
  endtask : wait_idle
  task automatic prog(input logic [7:0] b);
    snd(b);
    m_u.stop();
    repeat (8) @(negedge core_clk_i);
    wait_idle();
  endtask : prog
  // ----
  // scenarios
  // ----
  task automatic t_write();
    check("standby", {7'h0, standby}, 8'h01);
    set_addr(13'h011e);
    snd(8'ha5);
    snd(8'h5a);
    snd(8'hc3);
    m_u.stop();
    repeat (8) @(negedge core_clk_i);
    check("busy", {7'h0, busy}, 8'h01);
    check("standby", {7'h0, standby}, 8'h00);
    m_u.start();
    m_u.put_byte(dev(1'b0), ack);
    check("poll", {7'h0, ack}, 8'h01);
    m_u.stop();
    wait_idle();
    check("standby", {7'h0, standby}, 8'h01);
  endtask : t_write
  task automatic t_read();
    set_addr(13'h011e);
    m_u.start();
    snd(dev(1'b1));
    m_u.get_byte(1'b0, d);
    check("seq0", d, 8'ha5);
    m_u.get_byte(1'b1, d);
    check("seq1", d, 8'h5a);
    m_u.stop();
    repeat (8) @(negedge core_clk_i);
    check("standby", {7'h0, standby}, 8'h01);
    rd1(13'h0100, 8'hc3);
  endtask : t_read
  task automatic t_wp();
    wp = 1'b1;
    set_addr(13'h0100);
    snd(8'h0f);
    m_u.stop();
    repeat (8) @(negedge core_clk_i);
    check("busy", {7'h0, busy}, 8'h00);
    rd1(13'h0100, 8'hc3);
    @(negedge core_clk_i);
    wp = 1'b0;
    set_addr(13'h0100);
    prog(8'h0f);
    rd1(13'h0100, 8'h0f);
  endtask : t_wp
  task automatic t_refuse();
    logic [7:0] bad [2] = '{8'hba, 8'ha8};
    foreach (bad[i])
    begin
      m_u.start();
      m_u.put_byte(bad[i], ack);
      check("nack", {7'h0, ack}, 8'h01);
      m_u.stop();
    end
    m_u.start();
    for (int i = 0; i < 4; i++)
      m_u.put_bit(1'b1, ack);
    rd1(13'h0100, 8'h0f);
  endtask : t_refuse
  initial
  begin
    repeat (20) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    t_write();
    t_read();
    t_wp();
    t_refuse();
    summarize();
  end
endmodule : tb_ees_slave_port

//--- verilog/ees_line_if.sv
// conditioned link events passed from the pin sampler to the protocol core
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface ees_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start_det;
  logic stop_det;
  logic [2:0] strap;
  logic wp;

  modport sampler (output scl_rise, scl_fall, sda, start_det, stop_det, strap, wp);
  modport core (input scl_rise, scl_fall, sda, start_det, stop_det, strap, wp);
endinterface : ees_line_if

//--- verilog/ees_line_sync.sv
// pin sampler: two-flop synchronisers and bus condition detection
// assumes scl, sda, straps and write protect are asynchronous to core_clk_i
`timescale 1ns/1ps
module ees_line_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [2:0] strap_i,
  input wire logic wp_i,
  ees_line_if.sampler ln
);
  import ees_pkg::*;

  logic [5:0] meta;
  logic [5:0] sync;
  logic scl_d;
  logic sda_d;
  logic [5:0] next_meta;
  logic [5:0] next_sync;

  // ----------------------------------------------------------------
  // synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  always_comb
  begin
    next_meta = {scl_i, sda_i, strap_i, wp_i};
    next_sync = meta;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      meta <= 6'h30;
      sync <= 6'h30;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      scl_d <= sync[5];
      sda_d <= sync[4];
    end
  end

  // ----------------------------------------------------------------
  // edges and bus conditions
  // ----------------------------------------------------------------
  assign ln.sda = sync[4];
  assign ln.scl_rise = sync[5] & ~scl_d;
  assign ln.scl_fall = ~sync[5] & scl_d;
  assign ln.start_det = sync[5] & scl_d & sda_d & ~sync[4];
  assign ln.stop_det = sync[5] & scl_d & ~sda_d & sync[4];
  // an open strap pad has a pull-down, so it arrives here as low
  assign ln.strap = sync[3:1];
  assign ln.wp = sync[0];

endmodule : ees_line_sync

//--- verilog/ees_pkg.sv
// constants and types shared by the two-wire eeprom slave port
// assumes a single core clock; link pins are sampled, never used as clocks
package ees_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_PERIOD_NS = 20;
  // self-timed write cycle, longest time, so the count rounds down
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CORE_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // array organisation
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int MEM_BYTES = 8192;
  localparam int PAGE_IDX_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_NUM_W = 8;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_CNT_ACK = 4'h8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] DEV_PREFIX = 4'ha;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [PAGE_BYTES-1:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] PROG_CNT_RST = 32'h0000_0000;

  typedef enum logic [6:0] {
    ST_STANDBY = 7'h01,
    ST_DEV = 7'h02,
    ST_ADR_HI = 7'h04,
    ST_ADR_LO = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_IGNORE = 7'h40
  } ees_state_type;

endpackage : ees_pkg

//--- verilog/ees_slave_port.sv
// two-wire serial slave port of an 8192 x 8 eeprom with self-timed writes
// assumes an external pull-up on sda and a pull-down on each strap and wp pad
//
// How it works
// - sample on scl rise, drive on scl fall
// - floating strap pins read as low
// - sda is only pulled low or released
// - write protect high inhibits all programming
// - reads ignore write protect entirely
// - 256 pages of 32, 13-bit address
// - array holds 8192 bytes of 8 bits
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - stop after read returns to standby
// - stop after write programs, then standby
// - self-timed write finishes within 5 ms
// - acknowledge each 8-bit word on ninth clock
// - standby after power-up and after programming
// - device address prefix must be 1010
// - straps match address bits, else nack
// - eighth address bit selects read or write
// - partial page writes program only supplied bytes
// - each write erases targets automatically
// - two address bytes, inputs ignored while programming
// - page write increments low five bits
// - nack device address while programming runs
// - address counter advances and wraps
`timescale 1ns/1ps
module ees_slave_port #(
  parameter int WRITE_CYCLES = ees_pkg::WRITE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic chip_select_strap_hi_i,
  input wire logic chip_select_strap_mid_i,
  input wire logic chip_select_strap_lo_i,
  input wire logic write_protect_i,
  output logic standby_o,
  output logic prog_busy_o
);
  import ees_pkg::*;

  ees_line_if ln ();

  ees_state_type state;
  ees_state_type next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic drive_low;
  logic next_drive_low;
  logic load_pend;
  logic next_load_pend;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [PAGE_BYTES-1:0] mask;
  logic [PAGE_BYTES-1:0] next_mask;
  logic buf_we;
  logic prog_start;
  logic dev_match;

  logic prog_busy;
  logic next_prog_busy;
  logic [31:0] prog_cnt;
  logic [31:0] next_prog_cnt;
  logic [PAGE_NUM_W-1:0] prog_page;
  logic [PAGE_NUM_W-1:0] next_prog_page;
  logic commit;
  logic [PAGE_IDX_W-1:0] commit_idx;

  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_buf [PAGE_BYTES];
  logic [7:0] mem_q;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  ees_line_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .strap_i({chip_select_strap_hi_i, chip_select_strap_mid_i, chip_select_strap_lo_i}),
    .wp_i(write_protect_i),
    .ln(ln)
  );

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  assign dev_match = (shreg[7:4] == DEV_PREFIX)
    && (shreg[3:1] == ln.strap);

  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx = tx;
    next_drive_low = drive_low;
    next_load_pend = load_pend;
    next_addr = addr;
    next_mask = mask;
    buf_we = 1'b0;
    prog_start = 1'b0;
    if (ln.start_det)
    begin
      // abandon whatever byte was in flight
      next_state = ST_DEV;
      next_bit_cnt = BIT_CNT_RST;
      next_drive_low = 1'b0;
      next_load_pend = 1'b0;
    end
    else if (ln.stop_det)
    begin
      // mask is only non-zero after fresh data bytes of this command
      if (state == ST_WDATA && mask != MASK_RST && !ln.wp)
      begin
        prog_start = 1'b1;
      end
      next_state = ST_STANDBY;
      next_drive_low = 1'b0;
      next_load_pend = 1'b0;
    end
    else if (ln.scl_rise)
    begin
      if (bit_cnt != BIT_CNT_ACK)
      begin
        next_shreg = {shreg[6:0], ln.sda};
        next_bit_cnt = bit_cnt + 4'h1;
      end
      else
      begin
        next_bit_cnt = BIT_CNT_RST;
        if (state == ST_RDATA)
        begin
          // master ack asks for another byte, nack ends the read
          if (ln.sda)
          begin
            next_state = ST_IGNORE;
          end
          else
          begin
            next_load_pend = 1'b1;
          end
        end
      end
    end
    else if (ln.scl_fall)
    begin
      if (bit_cnt == BIT_CNT_ACK)
      begin
        case (state)
          ST_DEV:
          begin
            if (dev_match && !prog_busy)
            begin
              next_drive_low = 1'b1;
              next_load_pend = shreg[0];
              next_state = shreg[0] ? ST_RDATA : ST_ADR_HI;
            end
            else
            begin
              next_drive_low = 1'b0;
              next_state = ST_IGNORE;
            end
          end
          ST_ADR_HI:
          begin
            next_addr = {shreg[ADDR_W-9:0], addr[7:0]};
            next_drive_low = 1'b1;
            next_state = ST_ADR_LO;
          end
          ST_ADR_LO:
          begin
            next_addr = {addr[ADDR_W-1:8], shreg};
            next_mask = MASK_RST;
            next_drive_low = 1'b1;
            next_state = ST_WDATA;
          end
          ST_WDATA:
          begin
            // protected writes are still acknowledged
            buf_we = 1'b1;
            next_mask[addr[PAGE_IDX_W-1:0]] = 1'b1;
            next_addr = {addr[ADDR_W-1:PAGE_IDX_W], addr[PAGE_IDX_W-1:0] + 5'h01};
            next_drive_low = 1'b1;
          end
          default:
          begin
            // read byte done: let go so the master can answer
            next_drive_low = 1'b0;
          end
        endcase
      end
      else if (load_pend)
      begin
        next_tx = {mem_q[6:0], 1'b1};
        next_drive_low = ~mem_q[7];
        next_addr = addr + 13'h0001;
        next_load_pend = 1'b0;
      end
      else if (state == ST_RDATA && bit_cnt != BIT_CNT_RST)
      begin
        next_drive_low = ~tx[7];
        next_tx = {tx[6:0], 1'b1};
      end
      else
      begin
        next_drive_low = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_STANDBY;
      bit_cnt <= BIT_CNT_RST;
      shreg <= 8'h00;
      tx <= 8'hff;
      drive_low <= 1'b0;
      load_pend <= 1'b0;
      addr <= ADDR_RST;
      mask <= MASK_RST;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx <= next_tx;
      drive_low <= next_drive_low;
      load_pend <= next_load_pend;
      addr <= next_addr;
      mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // self-timed programming
  // ----------------------------------------------------------------
  // the first page-size cycles copy the buffer, the rest model the cell time
  assign commit_idx = prog_cnt[PAGE_IDX_W-1:0];
  assign commit = prog_busy && (prog_cnt < 32'(PAGE_BYTES)) && mask[commit_idx];

  always_comb
  begin
    next_prog_busy = prog_busy;
    next_prog_cnt = prog_cnt;
    next_prog_page = prog_page;
    if (prog_start)
    begin
      next_prog_busy = 1'b1;
      next_prog_cnt = PROG_CNT_RST;
      next_prog_page = addr[ADDR_W-1:PAGE_IDX_W];
    end
    else if (prog_busy)
    begin
      if (prog_cnt == 32'(WRITE_CYCLES - 1))
      begin
        next_prog_busy = 1'b0;
      end
      else
      begin
        next_prog_cnt = prog_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      prog_busy <= 1'b0;
      prog_cnt <= PROG_CNT_RST;
      prog_page <= 8'h00;
    end
    else
    begin
      prog_busy <= next_prog_busy;
      prog_cnt <= next_prog_cnt;
      prog_page <= next_prog_page;
    end
  end

  // ----------------------------------------------------------------
  // array and page buffer
  // ----------------------------------------------------------------
  // no erase step is visible: a committed byte simply replaces the old one
  always_ff @(posedge core_clk_i)
  begin
    if (buf_we)
    begin
      page_buf[addr[PAGE_IDX_W-1:0]] <= shreg;
    end
    if (commit)
    begin
      mem[{prog_page, commit_idx}] <= page_buf[commit_idx];
    end
    mem_q <= mem[addr];
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the pad is open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_low;
  assign standby_o = (state == ST_STANDBY) && !prog_busy;
  assign prog_busy_o = prog_busy;

endmodule : ees_slave_port
